// File: rtl/vsw_pkg.sv
package vsw_pkg;

   // register offsets as seen through the serial pointer
   localparam logic [7:0] OFS_COMPOSITE_A = 8'h02;
   localparam logic [7:0] OFS_COMPOSITE_B = 8'h03;
   localparam logic [7:0] OFS_SVIDEO_A    = 8'h04;
   localparam logic [7:0] OFS_SVIDEO_B    = 8'h05;
   localparam logic [7:0] OFS_COMPONENT_A = 8'h06;
   localparam logic [7:0] OFS_COMPONENT_B = 8'h07;
   localparam logic [7:0] OFS_MISC_GEN    = 8'h14;
   localparam logic [7:0] OFS_MISC_CLAMP  = 8'h16;

   localparam int         NUM_REGS        = 8;
   localparam logic [2:0] IDX_MISC_GEN    = 3'h6;
   localparam logic [7:0] REG_OFS [0:NUM_REGS-1] = '{OFS_COMPOSITE_A, OFS_COMPOSITE_B, OFS_SVIDEO_A,
                                                     OFS_SVIDEO_B, OFS_COMPONENT_A, OFS_COMPONENT_B,
                                                     OFS_MISC_GEN, OFS_MISC_CLAMP};

   localparam logic [7:0] CFG_RESET       = 8'h00;
   localparam logic [7:0] UNMAPPED_READ   = 8'h00;
   localparam logic [7:0] PTR_RESET       = 8'h00;
   localparam logic [7:0] MISC_GEN_WMASK  = 8'h0f;
   localparam int         GLOBAL_EN_BIT   = 0;
   localparam int         CHAN_EN_BIT     = 5;
   localparam int         CABLE_LSB       = 4;
   localparam int         NUM_CHANNELS    = 6;

   // fixed upper six bits of the 7-bit bus address
   localparam logic [5:0] DEV_ADDR_FIXED  = 6'h21;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic       LINE_IDLE       = 1'b1;
   // crystal periods a line must hold a new level before it is believed
   localparam int         FILTER_PERIODS  = 3;

   typedef struct packed {
      logic [7:0] composite_channel_a_ctrl;
      logic [7:0] composite_channel_b_ctrl;
      logic [7:0] svideo_channel_a_ctrl;
      logic [7:0] svideo_channel_b_ctrl;
      logic [7:0] component_channel_a_ctrl;
      logic [7:0] component_channel_b_ctrl;
      logic [7:0] general_control_and_cable_sense;
      logic [7:0] clamp_control;
   } cfg_regs_t;

   typedef enum logic [8:0] {
      ST_IDLE      = 9'b000000001,
      ST_ADDR      = 9'b000000010,
      ST_ACK_ADDR  = 9'b000000100,
      ST_PTR       = 9'b000001000,
      ST_ACK_PTR   = 9'b000010000,
      ST_WDATA     = 9'b000100000,
      ST_ACK_WDATA = 9'b001000000,
      ST_RDATA     = 9'b010000000,
      ST_RACK      = 9'b100000000
   } link_state_t;

   // {hit, index} for a pointer value
   function automatic logic [3:0] reg_lookup(input logic [7:0] ofs);
      logic [3:0] res;
      res = 4'h0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (REG_OFS[i] == ofs) begin
            res = {1'b1, 3'(i)};
         end
      end
      return res;
   endfunction

endpackage

// File: rtl/line_deglitch.sv
`timescale 1ns/1ps
module line_deglitch #(
   parameter int FILTER_CYCLES = vsw_pkg::FILTER_PERIODS
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [1:0] line_raw_i,
   output logic      [1:0] line_filt_o
);
   import vsw_pkg::*;

   localparam int CW = $clog2(FILTER_CYCLES + 1);

   logic [1:0]    sync1_reg;
   logic [1:0]    sync2_reg;
   logic [1:0]    out_reg;
   logic [1:0]    out_next;
   logic [CW-1:0] cnt_reg  [0:1];
   logic [CW-1:0] cnt_next [0:1];

   // a level is taken only after it has stood for the whole filter span
   always_comb begin
      out_next = out_reg;
      for (int i = 0; i < 2; i++) begin
         if (sync2_reg[i] == out_reg[i]) begin
            cnt_next[i] = '0;
         end else if (cnt_reg[i] == CW'(FILTER_CYCLES - 1)) begin
            out_next[i] = sync2_reg[i];
            cnt_next[i] = '0;
         end else begin
            cnt_next[i] = cnt_reg[i] + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync1_reg  <= {2{LINE_IDLE}};
         sync2_reg  <= {2{LINE_IDLE}};
         out_reg    <= {2{LINE_IDLE}};
         cnt_reg[0] <= '0;
         cnt_reg[1] <= '0;
      end else begin
         sync1_reg  <= line_raw_i;
         sync2_reg  <= sync1_reg;
         out_reg    <= out_next;
         cnt_reg[0] <= cnt_next[0];
         cnt_reg[1] <= cnt_next[1];
      end
   end

   assign line_filt_o = out_reg;

endmodule

// File: rtl/i2c_config_register_slave.sv
`timescale 1ns/1ps
// Behaviour
// - answer at 7-bit address, six bits fixed, lowest from strap pin.
// - unconnected strap pin reads as zero through its pull-down.
// - ignore all traffic until a START, data falling with clock high.
// - first byte is address plus direction; one reads, zero writes.
// - on own address, pull data low for the acknowledge bit.
// - transfer ends on STOP or repeated START.
// - first written byte after address loads the register pointer.
// - pointer increments after each written data byte.
// - reads return the pointed register, then increment the pointer.
// - serial clock delayed and filtered three crystal periods; bits sampled on delayed rise, register written on the delayed fall after bit eight.
// - read data changes only after the delayed falling clock edge.
// - host drives clock; device only pulls data low or releases it.
// - general register bit 0 gates every output enable.
module i2c_config_register_slave (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic             clk_link_i,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output logic                  sda_o,
   output logic                  sda_oe_o,
   input  wire logic             address_strap_bit_i,
   input  wire logic [3:0]       svideo_cable_absent_i,
   output vsw_pkg::cfg_regs_t    cfg_o,
   output logic [5:0]            chan_out_en_o
);
   import vsw_pkg::*;

   // link-domain reset, released two crystal edges after the system reset
   logic [1:0]  rst_link_sync_reg;
   logic        rst_link_n;

   always_ff @(posedge clk_link_i) begin
      rst_link_sync_reg <= {rst_link_sync_reg[0], rst_n_i};
   end
   assign rst_link_n = rst_link_sync_reg[1];

   // strap and cable pins, two flops before use
   logic [1:0]  strap_sync_reg;
   logic [3:0]  cable_sync1_reg;
   logic [3:0]  cable_sync2_reg;
   logic [6:0]  own_addr;

   always_ff @(posedge clk_link_i) begin
      if (!rst_link_n) begin
         strap_sync_reg  <= 2'h0;
         cable_sync1_reg <= 4'h0;
         cable_sync2_reg <= 4'h0;
      end else begin
         strap_sync_reg  <= {strap_sync_reg[0], address_strap_bit_i};
         cable_sync1_reg <= svideo_cable_absent_i;
         cable_sync2_reg <= cable_sync1_reg;
      end
   end
   // open pin reads low via the pad pull-down
   assign own_addr = {DEV_ADDR_FIXED, strap_sync_reg[1]};

   // delayed, de-glitched bus lines
   logic [1:0]  line_filt;
   logic        scl_f;
   logic        sda_f;
   logic        scl_d_reg;
   logic        sda_d_reg;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;

   line_deglitch #(
      .FILTER_CYCLES (FILTER_PERIODS)
   ) u_deglitch (
      .clk_i       (clk_link_i),
      .rst_n_i     (rst_link_n),
      .line_raw_i  ({sda_i, scl_i}),
      .line_filt_o (line_filt)
   );
   assign scl_f = line_filt[0];
   assign sda_f = line_filt[1];

   always_ff @(posedge clk_link_i) begin
      if (!rst_link_n) begin
         scl_d_reg <= LINE_IDLE;
         sda_d_reg <= LINE_IDLE;
      end else begin
         scl_d_reg <= scl_f;
         sda_d_reg <= sda_f;
      end
   end

   assign scl_rise   = scl_f & ~scl_d_reg;
   assign scl_fall   = ~scl_f & scl_d_reg;
   // data moves under a high clock only for START/STOP
   assign start_cond = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
   assign stop_cond  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

   // register file, link domain
   logic [7:0]  regs_reg  [0:NUM_REGS-1];
   logic [7:0]  regs_next [0:NUM_REGS-1];
   logic [7:0]  rd_byte;
   logic [3:0]  rd_hit;
   logic [3:0]  wr_hit;
   logic        wr_en;

   link_state_t state_reg;
   link_state_t state_next;
   logic [3:0]  bit_cnt_reg;
   logic [3:0]  bit_cnt_next;
   logic [7:0]  shift_reg;
   logic [7:0]  shift_next;
   logic [7:0]  ptr_reg;
   logic [7:0]  ptr_next;
   logic        rw_reg;
   logic        rw_next;
   logic        drive_reg;
   logic        drive_next;
   logic        mack_reg;
   logic        mack_next;

   // cable-sense bits are live pin state, not storage
   always_comb begin
      rd_hit  = reg_lookup(ptr_reg);
      rd_byte = UNMAPPED_READ;
      if (rd_hit[3]) begin
         rd_byte = regs_reg[rd_hit[2:0]];
         if (rd_hit[2:0] == IDX_MISC_GEN) begin
            rd_byte[CABLE_LSB +: 4] = cable_sync2_reg;
         end
      end
   end

   always_comb begin
      state_next   = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next   = shift_reg;
      ptr_next     = ptr_reg;
      rw_next      = rw_reg;
      drive_next   = drive_reg;
      mack_next    = mack_reg;
      wr_en        = 1'b0;
      if (start_cond) begin
         // also a repeated START mid-transfer
         state_next   = ST_ADDR;
         bit_cnt_next = 4'h0;
         drive_next   = 1'b0;
      end else if (stop_cond) begin
         state_next = ST_IDLE;
         drive_next = 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               drive_next = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (scl_rise) begin
                  shift_next   = {shift_reg[6:0], sda_f};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                  bit_cnt_next = 4'h0;
                  if (state_reg == ST_ADDR) begin
                     if (shift_reg[7:1] == own_addr) begin
                        drive_next = 1'b1;
                        rw_next    = shift_reg[0];
                        state_next = ST_ACK_ADDR;
                     end else begin
                        state_next = ST_IDLE;
                     end
                  end else if (state_reg == ST_PTR) begin
                     ptr_next   = shift_reg;
                     drive_next = 1'b1;
                     state_next = ST_ACK_PTR;
                  end else begin
                     wr_en      = 1'b1;
                     ptr_next   = ptr_reg + 8'h01;
                     drive_next = 1'b1;
                     state_next = ST_ACK_WDATA;
                  end
               end
            end
            ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WDATA: begin
               if (scl_fall) begin
                  drive_next   = 1'b0;
                  bit_cnt_next = 4'h0;
                  if (state_reg == ST_ACK_ADDR && rw_reg) begin
                     shift_next = rd_byte;
                     ptr_next   = ptr_reg + 8'h01;
                     drive_next = ~rd_byte[7];
                     state_next = ST_RDATA;
                  end else if (state_reg == ST_ACK_ADDR) begin
                     state_next = ST_PTR;
                  end else begin
                     state_next = ST_WDATA;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_reg == BITS_PER_BYTE) begin
                     drive_next = 1'b0;
                     state_next = ST_RACK;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     drive_next = ~shift_reg[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  mack_next = ~sda_f;
               end else if (scl_fall) begin
                  bit_cnt_next = 4'h0;
                  if (mack_reg) begin
                     shift_next = rd_byte;
                     ptr_next   = ptr_reg + 8'h01;
                     drive_next = ~rd_byte[7];
                     state_next = ST_RDATA;
                  end else begin
                     // host refused the byte; wait for STOP or START
                     state_next = ST_IDLE;
                  end
               end
            end
            default: begin
               state_next = ST_IDLE;
               drive_next = 1'b0;
            end
         endcase
      end
   end

   // writes to unmapped offsets are dropped; read-only nibble never stored
   always_comb begin
      wr_hit = reg_lookup(ptr_reg);
      for (int i = 0; i < NUM_REGS; i++) begin
         regs_next[i] = regs_reg[i];
      end
      if (wr_en && wr_hit[3]) begin
         if (wr_hit[2:0] == IDX_MISC_GEN) begin
            regs_next[wr_hit[2:0]] = shift_reg & MISC_GEN_WMASK;
         end else begin
            regs_next[wr_hit[2:0]] = shift_reg;
         end
      end
   end

   always_ff @(posedge clk_link_i) begin
      if (!rst_link_n) begin
         state_reg   <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         ptr_reg     <= PTR_RESET;
         rw_reg      <= 1'b0;
         drive_reg   <= 1'b0;
         mack_reg    <= 1'b0;
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_reg[i] <= CFG_RESET;
         end
      end else begin
         state_reg   <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg   <= shift_next;
         ptr_reg     <= ptr_next;
         rw_reg      <= rw_next;
         drive_reg   <= drive_next;
         mack_reg    <= mack_next;
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_reg[i] <= regs_next[i];
         end
      end
   end

   // open drain: only ever pull low
   assign sda_o    = 1'b0;
   assign sda_oe_o = drive_reg;

   // register image to system domain by toggle handshake
   cfg_regs_t   snap_reg;
   cfg_regs_t   snap_next;
   logic        pend_reg;
   logic        pend_next;
   logic        req_tgl_reg;
   logic        req_tgl_next;
   logic [1:0]  ack_sync_reg;
   logic        launch;
   // system-side request synchroniser, read back by the link side as acknowledge
   logic [2:0]  req_sync_reg;

   // snapshot held until acknowledged, so it is stable when sampled
   always_comb begin
      launch       = pend_reg & (req_tgl_reg == ack_sync_reg[1]);
      pend_next    = wr_en | (pend_reg & ~launch);
      req_tgl_next = req_tgl_reg ^ launch;
      snap_next    = snap_reg;
      if (launch) begin
         snap_next = {regs_reg[0], regs_reg[1], regs_reg[2], regs_reg[3],
                      regs_reg[4], regs_reg[5], regs_reg[6], regs_reg[7]};
      end
   end

   always_ff @(posedge clk_link_i) begin
      if (!rst_link_n) begin
         snap_reg     <= {NUM_REGS{CFG_RESET}};
         pend_reg     <= 1'b0;
         req_tgl_reg  <= 1'b0;
         ack_sync_reg <= 2'h0;
      end else begin
         snap_reg     <= snap_next;
         pend_reg     <= pend_next;
         req_tgl_reg  <= req_tgl_next;
         ack_sync_reg <= {ack_sync_reg[0], req_sync_reg[2]};
      end
   end

   cfg_regs_t   cfg_reg;
   cfg_regs_t   cfg_next;
   logic [5:0]  chan_en_reg;
   logic [5:0]  chan_en_next;
   logic [7:0]  chan_regs [0:NUM_CHANNELS-1];

   always_comb begin
      cfg_next = cfg_reg;
      if (req_sync_reg[2] != req_sync_reg[1]) begin
         cfg_next = snap_reg;
      end
      chan_regs = '{cfg_reg.composite_channel_a_ctrl, cfg_reg.composite_channel_b_ctrl,
                    cfg_reg.svideo_channel_a_ctrl, cfg_reg.svideo_channel_b_ctrl,
                    cfg_reg.component_channel_a_ctrl, cfg_reg.component_channel_b_ctrl};
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         chan_en_next[i] = chan_regs[i][CHAN_EN_BIT] &
                           cfg_reg.general_control_and_cable_sense[GLOBAL_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         req_sync_reg <= 3'h0;
         cfg_reg      <= {NUM_REGS{CFG_RESET}};
         chan_en_reg  <= 6'h00;
      end else begin
         req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
         cfg_reg      <= cfg_next;
         chan_en_reg  <= chan_en_next;
      end
   end

   assign cfg_o         = cfg_reg;
   assign chan_out_en_o = chan_en_reg;

   logic        byte_end;
   assign byte_end = scl_fall & (bit_cnt_reg == BITS_PER_BYTE) & ~start_cond & ~stop_cond;

   chk_ack_match: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      (state_reg == ST_ADDR && byte_end && shift_reg[7:1] == own_addr)
      |=> drive_reg && state_reg == ST_ACK_ADDR && rw_reg == $past(shift_reg[0]))
      else $error("own address not acknowledged");
   chk_nack_foreign: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      (state_reg == ST_ADDR && byte_end && shift_reg[7:1] != own_addr)
      |=> !drive_reg && state_reg == ST_IDLE)
      else $error("foreign address was acknowledged");
   chk_start_restart: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      start_cond |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0 && !drive_reg)
      else $error("start did not restart address phase");
   chk_idle_released: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      (state_reg == ST_IDLE && !start_cond) |=> state_reg == ST_IDLE && !sda_oe_o)
      else $error("idle slave left idle or drove data");
   chk_stop_ends: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      (stop_cond && !start_cond) |=> state_reg == ST_IDLE ##1 !sda_oe_o)
      else $error("stop did not end transfer");
   chk_ptr_load: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      (state_reg == ST_PTR && byte_end) |=> ptr_reg == $past(shift_reg) && state_reg == ST_ACK_PTR)
      else $error("pointer byte not loaded");
   chk_write_inc: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      wr_en |=> ptr_reg == $past(ptr_reg) + 8'h01 && drive_reg)
      else $error("pointer not advanced after write");
   chk_read_load: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      (state_reg == ST_ACK_ADDR && rw_reg && scl_fall && !start_cond && !stop_cond)
      |=> shift_reg == $past(rd_byte) && ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("read byte or pointer wrong");
   chk_drive_on_fall: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      $changed(drive_reg) |-> $past(scl_fall) || $past(start_cond) || $past(stop_cond) || $past(state_reg == ST_IDLE))
      else $error("data line moved outside a falling clock");
   chk_shift_on_rise: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      (state_reg == ST_ADDR && !scl_rise && !start_cond && !stop_cond) |=> $stable(shift_reg))
      else $error("address bit taken without a delayed rise");
   chk_drive_states: assert property (@(posedge clk_link_i) disable iff (!rst_link_n)
      sda_oe_o |-> state_reg inside {ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WDATA, ST_RDATA})
      else $error("data line pulled in a receive phase");
   chk_global_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !cfg_reg.general_control_and_cable_sense[GLOBAL_EN_BIT] |=> chan_out_en_o == 6'h00)
      else $error("outputs enabled with global enable low");

   cov_write: cover property (@(posedge clk_link_i) disable iff (!rst_link_n) wr_en);
   cov_read_ack: cover property (@(posedge clk_link_i) disable iff (!rst_link_n)
      state_reg == ST_RACK && scl_fall && mack_reg);
   cov_foreign: cover property (@(posedge clk_link_i) disable iff (!rst_link_n)
      state_reg == ST_ADDR && byte_end && shift_reg[7:1] != own_addr);
   cov_restart: cover property (@(posedge clk_link_i) disable iff (!rst_link_n)
      state_reg == ST_WDATA && start_cond);

endmodule

// File: verification/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
   input  wire logic clk_link_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // idle bus: both lines released high, clock stands still between frames
   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_link_i);
      #1;
   endtask
   task automatic start;
      sda_low_o = 1'b0;
      wt(7);
      scl_o = 1'b1;
      wt(10);
      sda_low_o = 1'b1;
      wt(10);
      scl_o = 1'b0;
   endtask
   task automatic stop;
      wt(7);
      sda_low_o = 1'b1;
      wt(7);
      scl_o = 1'b1;
      wt(10);
      sda_low_o = 1'b0;
      wt(10);
   endtask
   // nine clocks, msb first; tx bit 1 releases the line so the slave may drive it
   task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         scl_o = 1'b0;
         wt(7);
         sda_low_o = ~tx[i];
         wt(7);
         scl_o = 1'b1;
         wt(10);
         rx[i] = sda_i;
      end
      scl_o = 1'b0;
   endtask
endmodule

// File: verification/i2c_config_register_slave_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module i2c_config_register_slave_tb;
   import vsw_pkg::*;
   logic               clk_sys = 1'b0;
   logic               clk_link = 1'b0;
   logic               rst_n = 1'b0;
   logic               strap = 1'b0;
   logic [3:0]         cable = 4'ha;
   logic               scl;
   logic               host_low;
   logic               sda_oe;
   logic               sda_o;
   wire                sda_w;
   cfg_regs_t          cfg;
   logic [5:0]         en;
   logic [8:0]         r;
   int                 mismatches = 0;
   int                 total_checks = 0;
   localparam logic [7:0] CH [0:5] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h3c, 8'h3d};
   // pull-up: the line is low only while somebody pulls it
   assign sda_w = ~(host_low | (sda_oe & ~sda_o));
   initial forever #4 clk_sys = ~clk_sys;
   initial begin
      #1.3;
      forever #3 clk_link = ~clk_link;
   end
   i2c_config_register_slave DUT (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .clk_link_i(clk_link), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .address_strap_bit_i(strap),
      .svideo_cable_absent_i(cable), .cfg_o(cfg), .chan_out_en_o(en));
   i2c_host_model host (.clk_link_i(clk_link), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic send(input logic [7:0] b, input logic ack);
      host.bits9({b, 1'b1}, r);
      `CHK(r[0], ~ack)
   endtask
   task automatic rd(input logic [7:0] exp, input logic last);
      host.bits9({8'hff, last}, r);
      `CHK(r[8:1], exp)
   endtask
   // image crossing takes a handful of system clocks
   task automatic syswait;
      repeat (24) @(posedge clk_sys);
      #1;
   endtask
   initial begin
      // generous: about thirty bytes at roughly 1.3 us each
      #300000;
      mismatches++;
      give_verdict;
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (10) @(posedge clk_link);
      `CHK(cfg, 64'h0)
      `CHK(en, 6'h00)
      `CHK(sda_o, 1'b0)
      send(8'h84, 1'b0);
      host.stop;
      host.start;
      send(8'h84, 1'b1);
      send(OFS_COMPOSITE_A, 1'b1);
      for (int i = 0; i < 6; i++) send(CH[i], 1'b1);
      host.stop;
      syswait;
      `CHK(cfg[63:16], 48'h303132333c3d)
      `CHK(en, 6'h00)
      $display("test burst_write done");
      host.start;
      send(8'h84, 1'b1);
      send(OFS_MISC_GEN, 1'b1);
      send(8'hf1, 1'b1);
      send(8'h55, 1'b1);
      send(8'ha5, 1'b1);
      host.stop;
      syswait;
      `CHK(cfg[15:0], 16'h01a5)
      `CHK(en, 6'h3f)
      $display("test global_enable done");
      host.start;
      send(8'h84, 1'b1);
      send(8'h13, 1'b1);
      host.start;
      send(8'h85, 1'b1);
      rd(8'h00, 1'b0);
      rd(8'ha1, 1'b0);
      rd(8'h00, 1'b0);
      rd(8'ha5, 1'b1);
      host.stop;
      $display("test read_back done");
      host.start;
      send(8'h86, 1'b0);
      send(8'h16, 1'b0);
      host.stop;
      @(posedge clk_sys);
      #1 strap = 1'b1;
      repeat (10) @(posedge clk_link);
      host.start;
      send(8'h84, 1'b0);
      host.start;
      send(8'h86, 1'b1);
      send(OFS_MISC_GEN, 1'b1);
      send(8'h00, 1'b1);
      send(8'h55, 1'b1);
      send(8'h00, 1'b1);
      host.stop;
      syswait;
      `CHK(cfg[15:0], 16'h0000)
      `CHK(en, 6'h00)
      $display("test strap_address done");
      give_verdict;
   end
endmodule
